// ### core/splc_pkg.sv
// Package: register map, fields, states and timing for the port power controller
package splc_pkg;

    // Port count and upstream port index
    localparam int SPLC_NPORTS = 3;
    localparam int SPLC_UP_PORT = 0;

    // AXI4-Lite register byte offsets
    localparam logic [7:0] SPLC_OFF_PMCSR0 = 8'h00;
    localparam logic [7:0] SPLC_OFF_PMCSR1 = 8'h04;
    localparam logic [7:0] SPLC_OFF_PMCSR2 = 8'h08;
    localparam logic [7:0] SPLC_OFF_VENDOR = 8'h0C;
    localparam logic [7:0] SPLC_OFF_LINKCTL = 8'h10;
    localparam logic [7:0] SPLC_OFF_CONFIG = 8'h14;
    localparam logic [7:0] SPLC_OFF_STATUS = 8'h18;
    localparam logic [7:0] SPLC_OFF_PME = 8'h1C;

    // Power state field encodings and position
    localparam logic [1:0] SPLC_PS_D0 = 2'h0;
    localparam logic [1:0] SPLC_PS_D3HOT = 2'h3;
    localparam int SPLC_PS_LSB = 0;

    // Link control active-state field: bit0 L0s enable, bit1 L1 enable
    localparam int SPLC_ASPM_L0S_BIT = 0;
    localparam int SPLC_ASPM_L1_BIT = 1;

    // Entry delay fields in the vendor control register
    localparam int SPLC_DLY_W = 8;
    localparam int SPLC_L0S_DLY_LSB = 0;
    localparam int SPLC_L1_DLY_LSB = 8;
    localparam logic [SPLC_DLY_W-1:0] SPLC_L0S_DLY_RST = 8'h07;
    localparam logic [SPLC_DLY_W-1:0] SPLC_L1_DLY_RST = 8'h1F;

    // PME service time-out, in microseconds, and cycle count at 25 MHz
    localparam int SPLC_CLK_MHZ = 25;
    localparam int SPLC_PME_TO_US = 100;
    localparam int SPLC_PME_TO_CYC = SPLC_PME_TO_US * SPLC_CLK_MHZ;

    // AXI responses
    localparam logic [1:0] SPLC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SPLC_RESP_SLVERR = 2'h2;

    // Device power states, one-hot
    typedef enum logic [3:0] {
        SPLC_D0_UNINIT = 4'h1,
        SPLC_D0_ACTIVE = 4'h2,
        SPLC_D3_HOT = 4'h4,
        SPLC_D3_COLD = 4'h8
    } splc_dstate_e;

    // Link states, one-hot
    typedef enum logic [5:0] {
        SPLC_L_L0 = 6'h01,
        SPLC_L_L0S = 6'h02,
        SPLC_L_L1REQ = 6'h04,
        SPLC_L_L1 = 6'h08,
        SPLC_L_L23 = 6'h10,
        SPLC_L_L3 = 6'h20
    } splc_lstate_e;

    // Link-side status from the serial link layer
    typedef struct packed {
        logic idle;
        logic l1_ack;
        logic l1_nak;
        logic turnoff_ack;
        logic exit_req;
    } splc_link_in_s;

    // Link-side commands to the serial link layer
    typedef struct packed {
        logic enter_l0s;
        logic l1_request;
        logic enter_l1;
        logic l23_ready;
        logic block_packets;
        logic pme_send;
    } splc_link_out_s;

endpackage : splc_pkg

// ### core/splc_port.sv
// Per-port power state machine, entry timers and link state control
module splc_port
    import splc_pkg::*;
#(
    parameter bit IS_UP = 1'b0,
    parameter int PME_TO_CYC = SPLC_PME_TO_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Software control
    input wire logic ps_wr,
    input wire logic [1:0] ps_val,
    input wire logic configured,
    input wire logic l0s_en,
    input wire logic l1_en,
    input wire logic [SPLC_DLY_W-1:0] l0s_dly,
    input wire logic [SPLC_DLY_W-1:0] l1_dly,
    input wire logic power_off,
    input wire logic switch_low,
    input wire logic hp_event,
    input wire logic pme_serviced,
    // Link
    input wire splc_link_in_s lin,
    output splc_link_out_s lout,
    // Status
    output splc_dstate_e dstate,
    output splc_lstate_e lstate,
    output logic pme_pending
);

    splc_dstate_e next_dstate;
    splc_lstate_e next_lstate;
    logic [SPLC_DLY_W-1:0] l0s_cnt;
    logic [SPLC_DLY_W-1:0] l1_cnt;
    logic [$clog2(PME_TO_CYC+1)-1:0] pme_cnt;
    logic l0s_met;
    logic l1_met;
    logic l1_allow;
    logic pme_fire;

    // Device power state transitions
    always_comb begin
        next_dstate = dstate;
        unique case (dstate)
            SPLC_D0_UNINIT: if (configured) next_dstate = SPLC_D0_ACTIVE;
            SPLC_D0_ACTIVE: if (ps_wr && ps_val == SPLC_PS_D3HOT) next_dstate = SPLC_D3_HOT;
            SPLC_D3_HOT: begin
                if (power_off) begin
                    next_dstate = SPLC_D3_COLD;
                end else if (ps_wr && ps_val == SPLC_PS_D0) begin
                    next_dstate = SPLC_D0_UNINIT;
                end
            end
            SPLC_D3_COLD: next_dstate = SPLC_D3_COLD;
            default: next_dstate = SPLC_D0_UNINIT;
        endcase
    end

    // Device state register; reset, or a D0 write while in D3hot, returns to D0 uninitialized
    always_ff @(posedge aclk) begin
        if (!aresetn) dstate <= SPLC_D0_UNINIT;
        else dstate <= next_dstate;
    end

    // Entry timers, cleared when conditions lapse
    always_ff @(posedge aclk) begin
        if (!aresetn || !lin.idle || !l0s_en) l0s_cnt <= '0;
        else if (!l0s_met) l0s_cnt <= l0s_cnt + 1'b1;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || !lin.idle || !l1_en) l1_cnt <= '0;
        else if (!l1_met) l1_cnt <= l1_cnt + 1'b1;
    end
    assign l0s_met = (l0s_cnt >= l0s_dly);
    assign l1_met = (l1_cnt >= l1_dly);

    // D3hot permits L1; active-state L1 only from the upstream port
    assign l1_allow = (dstate == SPLC_D3_HOT) || (IS_UP && l1_met);

    // Link state transitions
    always_comb begin
        next_lstate = lstate;
        unique case (lstate)
            SPLC_L_L0: begin
                if (switch_low && lin.turnoff_ack) next_lstate = SPLC_L_L23;
                else if (l1_allow) next_lstate = SPLC_L_L1REQ;
                else if (l0s_en && lin.idle && l0s_met) next_lstate = SPLC_L_L0S;
            end
            SPLC_L_L0S: begin
                if (lin.exit_req || !lin.idle) next_lstate = SPLC_L_L0;
                else if (l1_allow) next_lstate = SPLC_L_L1REQ;
            end
            SPLC_L_L1REQ: begin
                if (lin.l1_ack) next_lstate = SPLC_L_L1;
                else if (lin.l1_nak) next_lstate = SPLC_L_L0;
            end
            SPLC_L_L1: if (lin.exit_req) next_lstate = SPLC_L_L0;
            SPLC_L_L23: if (power_off) next_lstate = SPLC_L_L3;
            SPLC_L_L3: next_lstate = SPLC_L_L3;
            default: next_lstate = SPLC_L_L0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) lstate <= SPLC_L_L0;
        else lstate <= next_lstate;
    end

    // PME: pending from D3hot, resent on service time-out, never in D3cold
    assign pme_fire = (pme_cnt == '0);
    always_ff @(posedge aclk) begin
        if (!aresetn || dstate == SPLC_D3_COLD) begin
            pme_pending <= 1'b0;
        end else if (!IS_UP && hp_event && dstate == SPLC_D3_HOT) begin
            pme_pending <= 1'b1;
        end else if (pme_serviced) begin
            pme_pending <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || !pme_pending) pme_cnt <= '0;
        else if (pme_fire) pme_cnt <= ($bits(pme_cnt))'(PME_TO_CYC - 1);
        else pme_cnt <= pme_cnt - 1'b1;
    end

    // Link commands from state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lout <= '0;
        end else begin
            lout.enter_l0s <= (next_lstate == SPLC_L_L0S);
            lout.l1_request <= (next_lstate == SPLC_L_L1REQ);
            lout.enter_l1 <= (next_lstate == SPLC_L_L1);
            lout.l23_ready <= (next_lstate == SPLC_L_L23);
            lout.block_packets <= (next_lstate == SPLC_L_L23) || (next_lstate == SPLC_L_L3);
            lout.pme_send <= pme_pending && pme_fire && dstate != SPLC_D3_COLD;
        end
    end

endmodule : splc_port

// ### core/splc_top.sv
// Top: AXI4-Lite registers and three port power controllers
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
module splc_top
    import splc_pkg::*;
#(
    parameter int PME_TO_CYC = SPLC_PME_TO_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Per-port link status and commands
    input wire splc_link_in_s link_in [SPLC_NPORTS],
    output splc_link_out_s link_out [SPLC_NPORTS],
    // Hot-plug events and power removal
    input wire logic [SPLC_NPORTS-1:0] hp_event,
    input wire logic power_off,
    // Whole switch in low power
    output logic switch_low
);

    logic [31:0] vendor_reg;
    logic [1:0] aspm_reg;
    logic [SPLC_NPORTS-1:0] config_reg;
    logic [1:0] ps_field [SPLC_NPORTS];
    logic [SPLC_NPORTS-1:0] ps_wr;
    logic [SPLC_NPORTS-1:0] pme_clr;
    logic [SPLC_NPORTS-1:0] pme_pend;
    splc_dstate_e dst [SPLC_NPORTS];
    splc_lstate_e lst [SPLC_NPORTS];
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    logic wr_hit;
    logic next_switch_low;

    // Write channel capture, address and data in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_go = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held <= 1'b0;
        end
    end

    // Write decode
    always_comb begin
        wr_hit = 1'b1;
        unique case (aw_addr)
            SPLC_OFF_PMCSR0, SPLC_OFF_PMCSR1, SPLC_OFF_PMCSR2, SPLC_OFF_VENDOR,
            SPLC_OFF_LINKCTL, SPLC_OFF_CONFIG, SPLC_OFF_PME: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SPLC_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? SPLC_RESP_OKAY : SPLC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Vendor control register holding both entry delays
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vendor_reg <= '0;
            vendor_reg[SPLC_L0S_DLY_LSB +: SPLC_DLY_W] <= SPLC_L0S_DLY_RST;
            vendor_reg[SPLC_L1_DLY_LSB +: SPLC_DLY_W] <= SPLC_L1_DLY_RST;
        end else if (wr_go && aw_addr == SPLC_OFF_VENDOR) begin
            if (w_strb[0]) vendor_reg[7:0] <= w_data[7:0];
            if (w_strb[1]) vendor_reg[15:8] <= w_data[15:8];
        end
    end

    // Link control active-state field
    always_ff @(posedge aclk) begin
        if (!aresetn) aspm_reg <= 2'h0;
        else if (wr_go && aw_addr == SPLC_OFF_LINKCTL && w_strb[0]) aspm_reg <= w_data[1:0];
    end

    // Bridge configured flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_reg <= '0;
        end else if (wr_go && aw_addr == SPLC_OFF_CONFIG && w_strb[0]) begin
            config_reg <= w_data[SPLC_NPORTS-1:0];
        end
    end

    // Per-port power control registers and controllers
    for (genvar p = 0; p < SPLC_NPORTS; p++) begin : g_port
        localparam logic [7:0] OFF = SPLC_OFF_PMCSR0 + 8'(4 * p);
        assign ps_wr[p] = wr_go && aw_addr == OFF && w_strb[0];
        assign pme_clr[p] = wr_go && aw_addr == SPLC_OFF_PME && w_strb[0] && w_data[p];

        always_ff @(posedge aclk) begin
            if (!aresetn) ps_field[p] <= SPLC_PS_D0;
            else if (ps_wr[p]) ps_field[p] <= w_data[SPLC_PS_LSB +: 2];
        end

        splc_port #(
            .IS_UP(p == SPLC_UP_PORT),
            .PME_TO_CYC(PME_TO_CYC)
        ) u_port (
            .aclk(aclk),
            .aresetn(aresetn),
            .ps_wr(ps_wr[p]),
            .ps_val(w_data[SPLC_PS_LSB +: 2]),
            .configured(config_reg[p]),
            .l0s_en(aspm_reg[SPLC_ASPM_L0S_BIT]),
            .l1_en(aspm_reg[SPLC_ASPM_L1_BIT]),
            .l0s_dly(vendor_reg[SPLC_L0S_DLY_LSB +: SPLC_DLY_W]),
            .l1_dly(vendor_reg[SPLC_L1_DLY_LSB +: SPLC_DLY_W]),
            .power_off(power_off),
            .switch_low(p == SPLC_UP_PORT && dst[SPLC_UP_PORT] == SPLC_D3_HOT),
            .hp_event(hp_event[p]),
            .pme_serviced(pme_clr[p] && !(hp_event[p] && dst[p] == SPLC_D3_HOT)),
            .lin(link_in[p]),
            .lout(link_out[p]),
            .dstate(dst[p]),
            .lstate(lst[p]),
            .pme_pending(pme_pend[p])
        );
    end

    // Whole switch low once upstream is in D3hot and turn-off is acknowledged
    assign next_switch_low = dst[SPLC_UP_PORT] == SPLC_D3_HOT &&
        (lst[SPLC_UP_PORT] == SPLC_L_L23 || lst[SPLC_UP_PORT] == SPLC_L_L3);
    always_ff @(posedge aclk) begin
        if (!aresetn) switch_low <= 1'b0;
        else switch_low <= next_switch_low;
    end

    // Read channel
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= SPLC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= SPLC_RESP_OKAY;
            unique case (s_axi_araddr)
                SPLC_OFF_PMCSR0: s_axi_rdata <= {30'h0, ps_field[0]};
                SPLC_OFF_PMCSR1: s_axi_rdata <= {30'h0, ps_field[1]};
                SPLC_OFF_PMCSR2: s_axi_rdata <= {30'h0, ps_field[2]};
                SPLC_OFF_VENDOR: s_axi_rdata <= {16'h0000, vendor_reg[15:0]};
                SPLC_OFF_LINKCTL: s_axi_rdata <= {30'h0, aspm_reg};
                SPLC_OFF_CONFIG: s_axi_rdata <= {29'h0, config_reg};
                SPLC_OFF_STATUS: s_axi_rdata <= {1'b0, switch_low,
                    dst[2], dst[1], dst[0], lst[2], lst[1], lst[0]};
                SPLC_OFF_PME: s_axi_rdata <= {29'h0, pme_pend};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= SPLC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : splc_top

// ### verification/splc_top_asserts.sv
// Checker: concurrent properties on the controller's top-level ports
module splc_top_asserts
    import splc_pkg::*;
#(
    parameter int PME_TO_CYC = SPLC_PME_TO_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // Link and power
    input wire splc_link_in_s link_in [SPLC_NPORTS],
    input wire splc_link_out_s link_out [SPLC_NPORTS],
    input wire logic power_off,
    input wire logic switch_low
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Link commands and bus answers
    property p_reset_quiet;
        disable iff (1'b0) !aresetn |=> link_out[0] == '0 && link_out[1] == '0
            && link_out[2] == '0 && !switch_low && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not idle in reset");
    property p_l1_needs_ack;
        $rose(link_out[0].enter_l1) |-> $past(link_in[0].l1_ack) || $past(link_in[0].l1_ack, 2);
    endproperty
    a_l1_needs_ack: assert property (p_l1_needs_ack) else $error("L1 without ack");
    property p_l23_blocks;
        link_out[0].l23_ready |-> link_out[0].block_packets;
    endproperty
    a_l23_blocks: assert property (p_l23_blocks) else $error("packets open in L23");
    property p_l23_after_ack;
        $rose(link_out[0].l23_ready)
            |-> $past(link_in[0].turnoff_ack) || $past(link_in[0].turnoff_ack, 2);
    endproperty
    a_l23_after_ack: assert property (p_l23_after_ack) else $error("L23 without ack");
    property p_switch_low;
        $rose(switch_low) |-> $past(link_out[0].l23_ready);
    endproperty
    a_switch_low: assert property (p_switch_low) else $error("switch low too early");
    property p_no_pme_cold;
        power_off && $past(power_off) && $past(power_off, 2)
            |-> !link_out[1].pme_send && !link_out[2].pme_send;
    endproperty
    a_no_pme_cold: assert property (p_no_pme_cold) else $error("PME sent unpowered");
    property p_pme_spacing;
        link_out[1].pme_send |=> !link_out[1].pme_send [*3];
    endproperty
    a_pme_spacing: assert property (p_pme_spacing) else $error("PME resent too soon");
    property p_l0s_held;
        $rose(link_out[1].enter_l0s)
            |-> $past(link_in[1].idle) && $past(link_in[1].idle, 2) && $past(link_in[1].idle, 3);
    endproperty
    a_l0s_held: assert property (p_l0s_held) else $error("L0s before delay");
    property p_b_after;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_b_after: assert property (p_b_after) else $error("write answer late");
    property p_aw_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("write taken while answering");
    property p_ar_resp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_ar_resp: assert property (p_ar_resp) else $error("read answer late");

    // Main scenarios reached
    c_l1: cover property ($rose(link_out[0].enter_l1));
    c_low: cover property ($rose(switch_low));
    c_pme: cover property (link_out[1].pme_send);
endmodule : splc_top_asserts

bind splc_top splc_top_asserts #(.PME_TO_CYC(PME_TO_CYC)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .link_in(link_in), .link_out(link_out),
    .power_off(power_off), .switch_low(switch_low)
);

// ### verification/splc_link_partner.sv
// Link partner model: idle, exit, L1 answer and turn-off acknowledge
module splc_link_partner
    import splc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bench controls
    input wire logic quiet,
    input wire logic wake,
    input wire logic nak_mode,
    input wire logic turnoff,
    // Link
    input wire splc_link_out_s lout,
    output splc_link_in_s lin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] wait_cnt;

    // Request age, so the answer comes late
    always_ff @(posedge aclk) begin
        if (!aresetn || !lout.l1_request) begin
            wait_cnt <= 2'h0;
        end else if (wait_cnt != 2'h3) begin
            wait_cnt <= wait_cnt + 2'h1;
        end
    end

    // Status lines seen by the port
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lin <= '0;
        end else begin
            lin.idle <= quiet && !wake;
            lin.exit_req <= wake;
            lin.l1_ack <= lout.l1_request && wait_cnt == 2'h2 && !nak_mode;
            lin.l1_nak <= lout.l1_request && wait_cnt == 2'h2 && nak_mode;
            lin.turnoff_ack <= turnoff;
        end
    end
endmodule : splc_link_partner

// ### verification/splc_top_tb.sv
// Testbench: register sequences and link scenarios for the port power controller
module splc_top_tb
    import splc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TO_CYC = 8;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1;
    logic s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rdat;
    splc_link_in_s link_in [SPLC_NPORTS];
    splc_link_out_s link_out [SPLC_NPORTS];
    logic [SPLC_NPORTS-1:0] hp_event = 3'h0;
    logic [SPLC_NPORTS-1:0] quiet = 3'h0;
    logic [SPLC_NPORTS-1:0] wake = 3'h0;
    logic power_off = 1'b0;
    logic nak_mode = 1'b0;
    logic turnoff = 1'b0;
    logic switch_low;
    int mismatches = 0;
    int tests_run = 0;
    int n;

    // Core clock, 40 ns period
    always #20 aclk = ~aclk;

    // Device under test with short PME time-out
    splc_top #(.PME_TO_CYC(TO_CYC)) DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .link_in(link_in), .link_out(link_out),
        .hp_event(hp_event), .power_off(power_off), .switch_low(switch_low)
    );

    // One link partner per port
    for (genvar i = 0; i < SPLC_NPORTS; i++) begin : g_lp
        splc_link_partner lp (
            .aclk(aclk), .aresetn(aresetn), .quiet(quiet[i]), .wake(wake[i]),
            .nak_mode(nak_mode), .turnoff(turnoff), .lout(link_out[i]), .lin(link_in[i])
        );
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
    endtask : axi_rd

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        axi_rd(a);
        check(nm, rdat, exp);
    endtask : rd_chk

    // Reads status until the masked fields settle
    task automatic poll(input logic [31:0] exp, input logic [31:0] m, input string nm);
        int k;
        k = 0;
        do begin
            axi_rd(SPLC_OFF_STATUS);
            k++;
        end while ((rdat & m) !== (exp & m) && k < 80);
        check(nm, rdat & m, exp & m);
    endtask : poll

    task automatic count_pme(input int p, input int cyc);
        n = 0;
        repeat (cyc) begin
            @(posedge aclk);
            if (link_out[p].pme_send === 1'b1) n++;
        end
    endtask : count_pme

    function automatic logic [31:0] st(splc_lstate_e a, splc_lstate_e b, splc_lstate_e c,
        splc_dstate_e x, splc_dstate_e y, splc_dstate_e z, logic s);
        return {1'b0, s, z, y, x, c, b, a};
    endfunction : st

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    // Watchdog, well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        give_verdict();
    end

    // Main sequence
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(SPLC_OFF_VENDOR, {16'h0000, SPLC_L1_DLY_RST, SPLC_L0S_DLY_RST}, "delays");
        rd_chk(SPLC_OFF_STATUS, st(SPLC_L_L0, SPLC_L_L0, SPLC_L_L0, SPLC_D0_UNINIT,
            SPLC_D0_UNINIT, SPLC_D0_UNINIT, 1'b0), "reset status");
        rd_chk(8'h20, 32'h0000_0000, "unmapped data");
        check("unmapped rresp", 32'(resp), 32'(SPLC_RESP_SLVERR));
        axi_wr(8'h20, 32'hFFFF_FFFF);
        check("unmapped bresp", 32'(resp), 32'(SPLC_RESP_SLVERR));
        axi_wr(SPLC_OFF_CONFIG, 32'h0000_0007);
        poll(st(SPLC_L_L0, SPLC_L_L0, SPLC_L_L0, SPLC_D0_ACTIVE, SPLC_D0_ACTIVE,
            SPLC_D0_ACTIVE, 1'b0), 32'h7FFF_FFFF, "configured");
        $display("test reset done");
        axi_wr(SPLC_OFF_VENDOR, 32'h0000_0A04);
        axi_wr(SPLC_OFF_LINKCTL, 32'h0000_0003);
        quiet <= 3'h7;
        poll(st(SPLC_L_L1, SPLC_L_L0S, SPLC_L_L0S, SPLC_D0_ACTIVE, SPLC_D0_ACTIVE,
            SPLC_D0_ACTIVE, 1'b0), 32'h7FFF_FFFF, "aspm");
        check("down l1 req", 32'(link_out[1].l1_request), 32'h0000_0000);
        nak_mode <= 1'b1;
        wake <= 3'h7;
        repeat (4) @(posedge aclk);
        wake <= 3'h0;
        n = 0;
        repeat (60) begin
            @(posedge aclk);
            quiet[2] <= ~quiet[2];
            if (link_out[0].enter_l1 === 1'b1 || link_out[2].enter_l0s === 1'b1) n++;
        end
        check("refused or lapsed", n, 0);
        nak_mode <= 1'b0;
        $display("test aspm done");
        axi_wr(SPLC_OFF_PMCSR1, {30'h0, SPLC_PS_D3HOT});
        poll(st(SPLC_L_L0, SPLC_L_L1, SPLC_L_L0, SPLC_D0_ACTIVE, SPLC_D3_HOT,
            SPLC_D0_ACTIVE, 1'b0), 32'h3FFC_0FC0, "d3hot port1");
        hp_event <= 3'h2;
        @(posedge aclk);
        hp_event <= 3'h0;
        count_pme(1, 3 * TO_CYC + 4);
        check("pme resend", 32'(n >= 2), 32'h0000_0001);
        rd_chk(SPLC_OFF_PME, 32'h0000_0002, "pme pending");
        axi_wr(SPLC_OFF_PME, 32'h0000_0002);
        rd_chk(SPLC_OFF_PME, 32'h0000_0000, "pme cleared");
        axi_wr(SPLC_OFF_CONFIG, 32'h0000_0005);
        axi_wr(SPLC_OFF_PMCSR1, {30'h0, SPLC_PS_D0});
        poll({4'h0, SPLC_D0_UNINIT, 22'h0}, 32'h03C0_0000, "d0 port1");
        rd_chk(SPLC_OFF_VENDOR, 32'h0000_0A04, "delays kept");
        $display("test port power done");
        quiet <= 3'h0;
        wake <= 3'h1;
        turnoff <= 1'b1;
        repeat (4) @(posedge aclk);
        wake <= 3'h0;
        axi_wr(SPLC_OFF_PMCSR0, {30'h0, SPLC_PS_D3HOT});
        poll(st(SPLC_L_L23, SPLC_L_L0, SPLC_L_L0, SPLC_D3_HOT, SPLC_D0_ACTIVE,
            SPLC_D0_ACTIVE, 1'b1), 32'h403C_003F, "switch low");
        check("blocked", 32'(link_out[0].block_packets), 32'h0000_0001);
        axi_wr(SPLC_OFF_PMCSR2, {30'h0, SPLC_PS_D3HOT});
        power_off <= 1'b1;
        @(posedge aclk);
        hp_event <= 3'h4;
        @(posedge aclk);
        hp_event <= 3'h0;
        count_pme(2, 3 * TO_CYC + 4);
        check("cold pme", n, 0);
        poll({2'h0, SPLC_D3_COLD, 26'h0}, 32'h3C00_0000, "d3cold port2");
        $display("test low power done");
        give_verdict();
    end
endmodule : splc_top_tb
